/* design/ndr_params.svh */
`ifndef NDR_PARAMS_SVH
`define NDR_PARAMS_SVH

// register window and port offsets
`define NDR_WINDOW          3'h4
`define NDR_OFS_NETDIAG     4'h6
`define NDR_OFS_MEDIA       4'ha

// media type and line status fields
`define NDR_MT_TP_BIT       15
`define NDR_MT_COAX_BIT     14
`define NDR_MT_ONE_BIT      13
`define NDR_MT_SQE_BIT      12
`define NDR_MT_LINK_BIT     11
`define NDR_MT_POL_BIT      10
`define NDR_MT_JAB_BIT      9
`define NDR_MT_UNSQ_BIT     8
`define NDR_MT_LKEN_BIT     7
`define NDR_MT_JEN_BIT      6
`define NDR_MT_CRS_BIT      5
`define NDR_MT_COL_BIT      4
`define NDR_MT_HBEN_BIT     3
`define NDR_MT_FCSP_BIT     2

// net diagnostic fields
`define NDR_ND_EXT_BIT      15
`define NDR_ND_CODEC_BIT    14
`define NDR_ND_MAC_BIT      13
`define NDR_ND_FIFO_BIT     12
`define NDR_ND_TXON_BIT     11
`define NDR_ND_RXON_BIT     10
`define NDR_ND_TXBUSY_BIT   9
`define NDR_ND_TXREC_BIT    8
`define NDR_ND_STAT_BIT     7
`define NDR_ND_REV_LSB      1
`define NDR_ND_LVD_BIT      0

// reset values of the writable fields
`define NDR_CTRL_RESET      1'b0
`define NDR_WORD_RESET      16'h0000

// revision code, value arbitrary
`define NDR_REVISION        5'h03

// oversize thresholds in bytes, frames longer than these are oversized
`define NDR_MAXLEN_STRIP    11'h5ea
`define NDR_MAXLEN_KEEP     11'h5ee

`endif

/* design/ndr_pkg.sv */
package ndr_pkg;

	typedef logic [15:0] ndr_word_t;
	typedef logic [10:0] ndr_len_t;
	typedef logic [3:0]  ndr_ofs_t;
	typedef logic [2:0]  ndr_win_t;

endpackage

/* design/ndr_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser; the first stage feeds only the second
module ndr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,    // core clock
	input  wire logic         rstn,   // async reset, active low
	input  wire logic [W-1:0] d,      // asynchronous inputs
	output logic      [W-1:0] q       // synchronised outputs
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end
endmodule

`default_nettype wire

/* design/ndr_regs.sv */
// Contract
// - media bit 15 reads one while twisted pair is the enabled medium
// - media bit 14 reads one while the coax transceiver is enabled
// - media bit 13 always reads one, writes ignored
// - media bits 12..8, 5, 4 show live line status, read only
// - media bit 7 link pulse enable, writable, resets zero; software uses carefully
// - media bit 6 jabber guard enable, resets zero, also enables polarity check
// - media bit 2 keeps received FCS as data when set, resets zero
// - oversize limit is 1514 bytes, or 1518 while FCS is kept
// - FCS is still checked and errors flagged while FCS is kept
// - FCS keep bit reads back one when written, proving the feature exists
// - media bits 1..0 and diagnostic bit 6 read zero
// - diagnostic bit 15 external loopback, read/write, resets zero
// - diagnostic bit 14 codec loopback, read/write, resets zero
// - diagnostic bit 13 controller output loopback, read/write, resets zero
// - diagnostic bit 12 FIFO loopback, read/write, resets zero
// - bit 11 transmitter on, cleared by reset/disable/error; bit 10 rx, bit 7 stats
// - bit 9 reads one while transmitting or deferring
// - bit 8 sets on jabber or underrun, needs transmit reset to clear
// - bits 5..1 read a fixed revision code
// - bit 0 write only, resets zero, requests chip reset if detector works
// - missing heartbeat counted only while heartbeat statistics enable is set
`timescale 1ns/1ps
`default_nettype none
`include "ndr_params.svh"

module ndr_regs (
	input  wire logic              clk,                      // 100 MHz core clock
	input  wire logic              rstn,                     // async reset, active low
	input  wire ndr_pkg::ndr_win_t io_window,                // currently selected window
	input  wire ndr_pkg::ndr_ofs_t io_addr,                  // port offset within window
	input  wire logic              io_wr,                    // word write strobe
	input  wire logic              io_rd,                    // word read strobe
	input  wire ndr_pkg::ndr_word_t io_wdata,                // write data
	output ndr_pkg::ndr_word_t     io_rdata,                 // read data, one cycle after io_rd
	input  wire logic              media_tp_sel,             // twisted pair chosen
	input  wire logic              media_coax_sel,           // coax transceiver chosen
	input  wire logic              line_heartbeat,           // pin: heartbeat seen
	input  wire logic              line_link,                // pin: link pulse valid
	input  wire logic              line_polarity,            // pin: polarity reversed
	input  wire logic              line_jabber,              // pin: jabber detected
	input  wire logic              line_unsquelch,           // pin: unsquelch
	input  wire logic              line_carrier,             // pin: carrier sense
	input  wire logic              line_collision,           // pin: collision
	input  wire logic              lvd_ok,                   // pin: brownout detector working
	input  wire logic              tx_enable_cmd,            // pulse: enable transmitter
	input  wire logic              tx_disable_cmd,           // pulse: disable transmitter
	input  wire logic              tx_reset_cmd,             // pulse: transmit reset
	input  wire logic              tx_error,                 // pulse: transmit error
	input  wire logic              tx_busy,                  // level: sending or deferring
	input  wire logic              rx_enable_cmd,            // pulse: enable receiver
	input  wire logic              rx_disable_cmd,           // pulse: disable receiver
	input  wire logic              rx_reset_cmd,             // pulse: receive reset
	input  wire logic              stats_enable_cmd,         // pulse: enable statistics
	input  wire logic              stats_disable_cmd,        // pulse: disable statistics
	input  wire logic              jabber_err,               // pulse: jabber error
	input  wire logic              underrun_err,             // pulse: transmit underrun
	input  wire logic              tx_no_heartbeat,          // pulse: frame sent without heartbeat
	input  wire logic              rx_done,                  // pulse: frame received
	input  wire ndr_pkg::ndr_len_t rx_len,                   // length of that frame with FCS
	input  wire logic              rx_fcs_bad,               // FCS mismatch of that frame
	output logic                   link_pulse_enable,        // link pulse checking on
	output logic                   jabber_guard_enable,      // jabber and polarity checks on
	output logic                   heartbeat_stat_enable,    // heartbeat statistic on
	output logic                   fcs_passthrough_enable,   // keep FCS as data
	output logic                   external_loop_enable,     // loop at the medium
	output logic                   codec_loop_enable,        // loop at codec output
	output logic                   mac_loop_enable,          // loop at controller output
	output logic                   fifo_loop_enable,         // tx FIFO straight into rx FIFO
	output logic                   transmitter_on,           // transmitter enabled
	output logic                   receiver_on,              // receiver enabled
	output logic                   counters_on,              // statistics enabled
	output logic                   transmit_recovery_needed, // transmit reset required
	output ndr_pkg::ndr_len_t      rx_max_len,               // oversize threshold
	output logic                   rx_oversize,              // pulse: frame too long
	output logic                   rx_fcs_error,             // pulse: FCS mismatch
	output logic                   rx_keep_fcs_bytes,        // pulse: count 4 FCS bytes
	output logic                   missed_heartbeat_count,   // pulse: bump missing statistic
	output logic                   chip_reset_req            // brownout test reset request
);
	import ndr_pkg::*;
	logic [7:0] line_s;
	logic       heartbeat_s, link_s, polarity_s, jabber_s;
	logic       unsquelch_s, carrier_s, collision_s, lvd_ok_s;
	// line status comes straight from the transceiver, off our clock
	ndr_sync #(
		.W(8)
	) u_line_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    ({line_heartbeat, line_link, line_polarity, line_jabber,
		        line_unsquelch, line_carrier, line_collision, lvd_ok}),
		.q    (line_s)
	);

	assign {heartbeat_s, link_s, polarity_s, jabber_s,
	        unsquelch_s, carrier_s, collision_s, lvd_ok_s} = line_s;

	logic hit_media;
	logic hit_diag;
	logic wr_media;
	logic wr_diag;
	assign hit_media = (io_window == `NDR_WINDOW) && (io_addr == `NDR_OFS_MEDIA);
	assign hit_diag  = (io_window == `NDR_WINDOW) && (io_addr == `NDR_OFS_NETDIAG);
	assign wr_media  = io_wr && hit_media;
	assign wr_diag   = io_wr && hit_diag;

	logic lken_r, lken_nxt;
	logic jen_r, jen_nxt;
	logic hben_r, hben_nxt;
	logic fcsp_r, fcsp_nxt;
	logic ext_r, ext_nxt;
	logic codec_r, codec_nxt;
	logic mac_r, mac_nxt;
	logic fifo_r, fifo_nxt;
	logic lvd_r, lvd_nxt;
	always_comb begin
		lken_nxt  = lken_r;
		jen_nxt   = jen_r;
		hben_nxt  = hben_r;
		fcsp_nxt  = fcsp_r;
		ext_nxt   = ext_r;
		codec_nxt = codec_r;
		mac_nxt   = mac_r;
		fifo_nxt  = fifo_r;
		lvd_nxt   = lvd_r;
		if (wr_media) begin
			lken_nxt = io_wdata[`NDR_MT_LKEN_BIT];
			jen_nxt  = io_wdata[`NDR_MT_JEN_BIT];
			hben_nxt = io_wdata[`NDR_MT_HBEN_BIT];
			fcsp_nxt = io_wdata[`NDR_MT_FCSP_BIT];
		end
		if (wr_diag) begin
			ext_nxt   = io_wdata[`NDR_ND_EXT_BIT];
			codec_nxt = io_wdata[`NDR_ND_CODEC_BIT];
			mac_nxt   = io_wdata[`NDR_ND_MAC_BIT];
			fifo_nxt  = io_wdata[`NDR_ND_FIFO_BIT];
			lvd_nxt   = io_wdata[`NDR_ND_LVD_BIT];
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lken_r  <= `NDR_CTRL_RESET;
			jen_r   <= `NDR_CTRL_RESET;
			hben_r  <= `NDR_CTRL_RESET;
			fcsp_r  <= `NDR_CTRL_RESET;
			ext_r   <= `NDR_CTRL_RESET;
			codec_r <= `NDR_CTRL_RESET;
			mac_r   <= `NDR_CTRL_RESET;
			fifo_r  <= `NDR_CTRL_RESET;
			lvd_r   <= `NDR_CTRL_RESET;
		end else begin
			lken_r  <= lken_nxt;
			jen_r   <= jen_nxt;
			hben_r  <= hben_nxt;
			fcsp_r  <= fcsp_nxt;
			ext_r   <= ext_nxt;
			codec_r <= codec_nxt;
			mac_r   <= mac_nxt;
			fifo_r  <= fifo_nxt;
			lvd_r   <= lvd_nxt;
		end
	end

	assign link_pulse_enable      = lken_r;
	assign jabber_guard_enable    = jen_r;
	assign heartbeat_stat_enable  = hben_r;
	assign fcs_passthrough_enable = fcsp_r;
	assign external_loop_enable   = ext_r;
	assign codec_loop_enable      = codec_r;
	assign mac_loop_enable        = mac_r;
	assign fifo_loop_enable       = fifo_r;

	logic txon_r, txon_nxt;
	logic rxon_r, rxon_nxt;
	logic stat_r, stat_nxt;
	logic txrec_r, txrec_nxt;
	always_comb begin
		// transmitter on, any clear source wins over enable
		txon_nxt = txon_r;
		if (tx_enable_cmd)
			txon_nxt = 1'b1;
		if (tx_reset_cmd || tx_disable_cmd || tx_error)
			txon_nxt = 1'b0;
		rxon_nxt = rxon_r;
		if (rx_enable_cmd)
			rxon_nxt = 1'b1;
		if (rx_reset_cmd || rx_disable_cmd)
			rxon_nxt = 1'b0;
		stat_nxt = stat_r;
		if (stats_enable_cmd)
			stat_nxt = 1'b1;
		if (stats_disable_cmd)
			stat_nxt = 1'b0;
		// error sets, reset clears, a new error wins
		txrec_nxt = txrec_r;
		if (tx_reset_cmd)
			txrec_nxt = 1'b0;
		if (jabber_err || underrun_err)
			txrec_nxt = 1'b1;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txon_r  <= 1'b0;
			rxon_r  <= 1'b0;
			stat_r  <= 1'b0;
			txrec_r <= 1'b0;
		end else begin
			txon_r  <= txon_nxt;
			rxon_r  <= rxon_nxt;
			stat_r  <= stat_nxt;
			txrec_r <= txrec_nxt;
		end
	end

	assign transmitter_on           = txon_r;
	assign receiver_on              = rxon_r;
	assign counters_on              = stat_r;
	assign transmit_recovery_needed = txrec_r;

	ndr_len_t maxlen_r, maxlen_nxt;
	logic     ovr_r, ovr_nxt;
	logic     fcse_r, fcse_nxt;
	logic     keep_r, keep_nxt;
	logic     mhb_r, mhb_nxt;
	logic     crst_r, crst_nxt;
	always_comb begin
		maxlen_nxt = fcsp_r ? `NDR_MAXLEN_KEEP : `NDR_MAXLEN_STRIP;
		ovr_nxt    = rx_done && (rx_len > maxlen_r);
		// check runs whatever the keep bit
		fcse_nxt   = rx_done && rx_fcs_bad;
		keep_nxt   = rx_done && fcsp_r;
		mhb_nxt    = tx_no_heartbeat && hben_r;
		crst_nxt   = lvd_r && lvd_ok_s;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			maxlen_r <= `NDR_MAXLEN_STRIP;
			ovr_r    <= 1'b0;
			fcse_r   <= 1'b0;
			keep_r   <= 1'b0;
			mhb_r    <= 1'b0;
			crst_r   <= 1'b0;
		end else begin
			maxlen_r <= maxlen_nxt;
			ovr_r    <= ovr_nxt;
			fcse_r   <= fcse_nxt;
			keep_r   <= keep_nxt;
			mhb_r    <= mhb_nxt;
			crst_r   <= crst_nxt;
		end
	end

	assign rx_max_len             = maxlen_r;
	assign rx_oversize            = ovr_r;
	assign rx_fcs_error           = fcse_r;
	assign rx_keep_fcs_bytes      = keep_r;
	assign missed_heartbeat_count = mhb_r;
	assign chip_reset_req         = crst_r;

	ndr_word_t media_word;
	ndr_word_t diag_word;
	ndr_word_t rdata_r, rdata_nxt;
	always_comb begin
		media_word = `NDR_WORD_RESET;
		media_word[`NDR_MT_TP_BIT]   = media_tp_sel;
		media_word[`NDR_MT_COAX_BIT] = media_coax_sel;
		media_word[`NDR_MT_ONE_BIT]  = 1'b1;
		media_word[`NDR_MT_SQE_BIT]  = heartbeat_s;
		media_word[`NDR_MT_LINK_BIT] = link_s;
		media_word[`NDR_MT_POL_BIT]  = polarity_s;
		media_word[`NDR_MT_JAB_BIT]  = jabber_s;
		media_word[`NDR_MT_UNSQ_BIT] = unsquelch_s;
		media_word[`NDR_MT_CRS_BIT]  = carrier_s;
		media_word[`NDR_MT_COL_BIT]  = collision_s;
		media_word[`NDR_MT_LKEN_BIT] = lken_r;
		media_word[`NDR_MT_JEN_BIT]  = jen_r;
		media_word[`NDR_MT_HBEN_BIT] = hben_r;
		media_word[`NDR_MT_FCSP_BIT] = fcsp_r;
		// bits 1..0 stay zero from the default above
		diag_word = `NDR_WORD_RESET;
		diag_word[`NDR_ND_EXT_BIT]    = ext_r;
		diag_word[`NDR_ND_CODEC_BIT]  = codec_r;
		diag_word[`NDR_ND_MAC_BIT]    = mac_r;
		diag_word[`NDR_ND_FIFO_BIT]   = fifo_r;
		diag_word[`NDR_ND_TXON_BIT]   = txon_r;
		diag_word[`NDR_ND_RXON_BIT]   = rxon_r;
		diag_word[`NDR_ND_TXBUSY_BIT] = tx_busy;
		diag_word[`NDR_ND_TXREC_BIT]  = txrec_r;
		diag_word[`NDR_ND_STAT_BIT]   = stat_r;
		diag_word[`NDR_ND_REV_LSB +: 5] = `NDR_REVISION;
		// write-only test bit is never shown, so bit 0 reads zero; bit 6 stays zero from the default above
		rdata_nxt = rdata_r;
		if (io_rd) begin
			if (hit_media)
				rdata_nxt = media_word;
			else if (hit_diag)
				rdata_nxt = diag_word;
			else
				rdata_nxt = `NDR_WORD_RESET;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rdata_r <= `NDR_WORD_RESET;
		else
			rdata_r <= rdata_nxt;
	end

	assign io_rdata = rdata_r;
endmodule

`default_nettype wire

/* verif/ndr_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ndr_params.svh"

module ndr_regs_properties (
	input wire logic              clk,                      // clock
	input wire logic              rstn,                     // reset
	input wire ndr_pkg::ndr_win_t io_window,                // window
	input wire ndr_pkg::ndr_ofs_t io_addr,                  // offset
	input wire logic              io_rd,                    // read
	input wire ndr_pkg::ndr_word_t io_rdata,                // read data
	input wire logic              tx_busy,                  // busy
	input wire logic              tx_disable_cmd,           // off
	input wire logic              tx_reset_cmd,             // reset
	input wire logic              tx_error,                 // error
	input wire logic              jabber_err,               // jabber
	input wire logic              underrun_err,             // underrun
	input wire logic              tx_no_heartbeat,          // no beat
	input wire logic              rx_done,                  // frame
	input wire ndr_pkg::ndr_len_t rx_len,                   // length
	input wire logic              rx_fcs_bad,               // bad fcs
	input wire logic              fcs_passthrough_enable,   // keep fcs
	input wire logic              heartbeat_stat_enable,    // beat stat
	input wire logic              transmitter_on,           // tx on
	input wire logic              transmit_recovery_needed, // recovery
	input wire ndr_pkg::ndr_len_t rx_max_len,               // limit
	input wire logic              rx_oversize,              // too long
	input wire logic              rx_fcs_error,             // fcs error
	input wire logic              rx_keep_fcs_bytes,        // keep bytes
	input wire logic              missed_heartbeat_count    // beat count
);
	import ndr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_maxlen;
		rx_max_len == ($past(fcs_passthrough_enable) ? `NDR_MAXLEN_KEEP : `NDR_MAXLEN_STRIP);
	endproperty
	a_maxlen: assert property (p_maxlen) else $error("bad length limit");
	property p_ovs;
		rx_oversize == $past(rx_done && (rx_len > rx_max_len));
	endproperty
	a_ovs: assert property (p_ovs) else $error("bad oversize pulse");
	property p_fcserr;
		rx_done |=> rx_fcs_error == $past(rx_fcs_bad);
	endproperty
	a_fcserr: assert property (p_fcserr) else $error("bad fcs flag");
	property p_keep;
		rx_keep_fcs_bytes == $past(rx_done && fcs_passthrough_enable);
	endproperty
	a_keep: assert property (p_keep) else $error("bad fcs byte count");
	property p_hb;
		tx_no_heartbeat |=> missed_heartbeat_count == $past(heartbeat_stat_enable);
	endproperty
	a_hb: assert property (p_hb) else $error("bad beat count");
	property p_rec;
		jabber_err || underrun_err |=> transmit_recovery_needed;
	endproperty
	a_rec: assert property (p_rec) else $error("recovery not set");
	property p_recclr;
		tx_reset_cmd && !jabber_err && !underrun_err |=> !transmit_recovery_needed;
	endproperty
	a_recclr: assert property (p_recclr) else $error("recovery not cleared");
	property p_txoff;
		tx_disable_cmd || tx_reset_cmd || tx_error |=> !transmitter_on;
	endproperty
	a_txoff: assert property (p_txoff) else $error("transmitter stays on");
	property p_media;
		io_rd && io_window == `NDR_WINDOW && io_addr == `NDR_OFS_MEDIA
			|=> io_rdata[13] && io_rdata[1:0] == 2'h0;
	endproperty
	a_media: assert property (p_media) else $error("bad fixed media bits");
	property p_diag;
		io_rd && io_window == `NDR_WINDOW && io_addr == `NDR_OFS_NETDIAG
			|=> io_rdata[6:0] == {2'h0, `NDR_REVISION} << 1 && io_rdata[9] == $past(tx_busy);
	endproperty
	a_diag: assert property (p_diag) else $error("bad diag read");
endmodule

`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ndr_params.svh"

module testbench;
	import ndr_pkg::*;
	logic      clk, rstn, io_wr, io_rd, media_tp_sel, media_coax_sel, lvd_ok;
	ndr_win_t  io_window;
	ndr_ofs_t  io_addr;
	ndr_word_t io_wdata, io_rdata, v;
	ndr_len_t  rx_len, rx_max_len;
	logic      line_heartbeat, line_link, line_polarity, line_jabber;
	logic      line_unsquelch, line_carrier, line_collision;
	logic      tx_enable_cmd, tx_disable_cmd, tx_reset_cmd, tx_error, tx_busy;
	logic      rx_enable_cmd, rx_disable_cmd, rx_reset_cmd, stats_enable_cmd;
	logic      stats_disable_cmd, jabber_err, underrun_err, tx_no_heartbeat;
	logic      rx_done, rx_fcs_bad, link_pulse_enable, jabber_guard_enable;
	logic      heartbeat_stat_enable, fcs_passthrough_enable, external_loop_enable;
	logic      codec_loop_enable, mac_loop_enable, fifo_loop_enable, transmitter_on;
	logic      receiver_on, counters_on, transmit_recovery_needed, rx_oversize;
	logic      rx_fcs_error, rx_keep_fcs_bytes, missed_heartbeat_count, chip_reset_req;
	int        errors, n_compared;
	ndr_word_t lmap [7] = '{16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100,
		16'h0020, 16'h0010};

	ndr_regs ndr_regs_i (
		.clk, .rstn, .io_window, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
		.media_tp_sel, .media_coax_sel, .line_heartbeat, .line_link, .line_polarity,
		.line_jabber, .line_unsquelch, .line_carrier, .line_collision, .lvd_ok,
		.tx_enable_cmd, .tx_disable_cmd, .tx_reset_cmd, .tx_error, .tx_busy,
		.rx_enable_cmd, .rx_disable_cmd, .rx_reset_cmd, .stats_enable_cmd,
		.stats_disable_cmd, .jabber_err, .underrun_err, .tx_no_heartbeat, .rx_done,
		.rx_len, .rx_fcs_bad, .link_pulse_enable, .jabber_guard_enable,
		.heartbeat_stat_enable, .fcs_passthrough_enable, .external_loop_enable,
		.codec_loop_enable, .mac_loop_enable, .fifo_loop_enable, .transmitter_on,
		.receiver_on, .counters_on, .transmit_recovery_needed, .rx_max_len,
		.rx_oversize, .rx_fcs_error, .rx_keep_fcs_bytes, .missed_heartbeat_count,
		.chip_reset_req
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// inputs move 1 ns after the edge so no race with the design's sampling
	task automatic step;
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input ndr_word_t got, input ndr_word_t exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input ndr_ofs_t a, input ndr_word_t d);
		step;
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		step;
		io_wr = 1'b0;
	endtask

	task automatic rchk(input ndr_ofs_t a, input ndr_word_t e);
		step;
		io_addr = a;
		io_rd = 1'b1;
		step;
		io_rd = 1'b0;
		chk(io_rdata, e);
	endtask

	task automatic frame(input ndr_len_t n, input logic bad, input logic [2:0] e);
		step;
		rx_len = n;
		rx_fcs_bad = bad;
		rx_done = 1'b1;
		step;
		rx_done = 1'b0;
		chk({rx_oversize, rx_fcs_error, rx_keep_fcs_bytes}, e);
	endtask

	task automatic beat(input logic e);
		step;
		tx_no_heartbeat = 1'b1;
		step;
		tx_no_heartbeat = 1'b0;
		chk(missed_heartbeat_count, e); // beat statistic gating
	endtask

	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		tally_and_finish;
	end

	initial begin
		{io_wr, io_rd, media_coax_sel, lvd_ok, line_heartbeat, line_link, line_polarity,
			line_jabber, line_unsquelch, line_carrier, line_collision, tx_enable_cmd,
			tx_disable_cmd, tx_reset_cmd, tx_error, tx_busy, rx_enable_cmd, rx_disable_cmd,
			rx_reset_cmd, stats_enable_cmd, stats_disable_cmd, jabber_err, underrun_err,
			tx_no_heartbeat, rx_done, rx_fcs_bad, io_addr, io_wdata, rx_len} = '0;
		io_window = `NDR_WINDOW;
		media_tp_sel = 1'b1;
		errors = 0;
		n_compared = 0;
		rstn = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		rstn = 1'b1;
		lvd_ok = 1'b1;
		rchk(`NDR_OFS_MEDIA, 16'ha000); // reset view
		rchk(`NDR_OFS_NETDIAG, 16'h0006); // reset view
		chk(rx_max_len, 16'h05ea); // strip limit
		wr(`NDR_OFS_MEDIA, 16'hffff);
		chk({link_pulse_enable, jabber_guard_enable, heartbeat_stat_enable,
			fcs_passthrough_enable}, 16'h000f); // controls set
		rchk(`NDR_OFS_MEDIA, 16'ha0cc); // readback
		chk(rx_max_len, 16'h05ee); // keep limit
		{media_tp_sel, media_coax_sel} = 2'h1;
		for (int i = 0; i < 7; i++) begin
			{line_heartbeat, line_link, line_polarity, line_jabber, line_unsquelch,
				line_carrier, line_collision} = 7'h40 >> i;
			repeat (3) step;
			rchk(`NDR_OFS_MEDIA, 16'h60cc | lmap[i]); // line status
		end
		{line_collision, media_tp_sel, media_coax_sel} = 3'h2;
		wr(`NDR_OFS_NETDIAG, 16'hffff);
		// reset request follows the stored test bit one edge later
		step;
		chk({external_loop_enable, codec_loop_enable, mac_loop_enable, fifo_loop_enable,
			chip_reset_req}, 16'h001f); // loop modes
		rchk(`NDR_OFS_NETDIAG, 16'hf006); // diag readback
		wr(`NDR_OFS_NETDIAG, 16'h0000);
		step;
		chk({external_loop_enable, codec_loop_enable, mac_loop_enable, fifo_loop_enable,
			chip_reset_req}, 16'h0000); // loops off
		lvd_ok = 1'b0;
		wr(`NDR_OFS_NETDIAG, 16'h0001);
		repeat (3) step;
		chk(chip_reset_req, 16'h0); // no reset while detector is broken
		wr(`NDR_OFS_NETDIAG, 16'h0000);
		tx_busy = 1'b1;
		// transmitter, receiver and statistics enabled together while tx_busy is high
		{tx_enable_cmd, rx_enable_cmd, stats_enable_cmd} = 3'h7;
		step;
		{tx_enable_cmd, rx_enable_cmd, stats_enable_cmd} = 3'h0;
		rchk(`NDR_OFS_NETDIAG, 16'h0e86); // status view
		for (int i = 0; i < 3; i++) begin
			step;
			tx_enable_cmd = 1'b1;
			step;
			tx_enable_cmd = 1'b0;
			chk(transmitter_on, 16'h1); // enabled
			{tx_reset_cmd, tx_disable_cmd, tx_error} = 3'h4 >> i;
			step;
			{tx_reset_cmd, tx_disable_cmd, tx_error} = 3'h0;
			chk({transmitter_on, receiver_on, counters_on}, 16'h3); // cleared
		end
		{rx_disable_cmd, stats_disable_cmd} = 2'h3;
		step;
		{rx_disable_cmd, stats_disable_cmd} = 2'h0;
		chk({receiver_on, counters_on}, 16'h0); // rx and stats off
		rx_enable_cmd = 1'b1;
		step;
		rx_enable_cmd = 1'b0;
		chk(receiver_on, 16'h1); // rx enabled again
		rx_reset_cmd = 1'b1;
		step;
		rx_reset_cmd = 1'b0;
		chk(receiver_on, 16'h0); // rx reset clears
		jabber_err = 1'b1;
		step;
		jabber_err = 1'b0;
		rchk(`NDR_OFS_NETDIAG, 16'h0306); // recovery shown
		tx_reset_cmd = 1'b1;
		step;
		tx_reset_cmd = 1'b0;
		chk(transmit_recovery_needed, 16'h0); // reset clears
		step;
		{underrun_err, tx_reset_cmd} = 2'h3;
		step;
		{underrun_err, tx_reset_cmd} = 2'h0;
		chk(transmit_recovery_needed, 16'h1); // error wins
		frame(11'h5ee, 1'b0, 3'h1); // at keep limit
		frame(11'h5ef, 1'b1, 3'h7); // over keep limit
		beat(1'b1);
		wr(`NDR_OFS_MEDIA, 16'h0000);
		frame(11'h5eb, 1'b1, 3'h6); // over strip limit
		frame(11'h5ea, 1'b0, 3'h0); // at strip limit
		beat(1'b0);
		rchk(4'h4, 16'h0000); // unmapped offset
		io_window = 3'h3;
		wr(`NDR_OFS_MEDIA, 16'hffff);
		rchk(`NDR_OFS_MEDIA, 16'h0000); // other window
		io_window = `NDR_WINDOW;
		rchk(`NDR_OFS_MEDIA, 16'ha000); // write elsewhere ignored
		tally_and_finish;
	end
endmodule

bind ndr_regs ndr_regs_properties ndr_regs_properties_i (
	.clk, .rstn, .io_window, .io_addr, .io_rd, .io_rdata, .tx_busy, .tx_disable_cmd,
	.tx_reset_cmd, .tx_error, .jabber_err, .underrun_err, .tx_no_heartbeat, .rx_done,
	.rx_len, .rx_fcs_bad, .fcs_passthrough_enable, .heartbeat_stat_enable,
	.transmitter_on, .transmit_recovery_needed, .rx_max_len, .rx_oversize,
	.rx_fcs_error, .rx_keep_fcs_bytes, .missed_heartbeat_count
);

`default_nettype wire
